// ==== hdl/csd_pkg.sv ====
// Purpose: Shared constants for the chip select address decoder.
// Assumes: Register offsets are byte addresses on a 32-bit AHB-Lite bus.
// Notes: Only the low twelve address bits select a register; hsel does the rest.
package csd_pkg;

  // ==========================================================================
  // Register map
  localparam logic [31:0] OFF_BASE_MASK_SPACE0 = 32'hffffe400;
  localparam logic [31:0] OFF_BASE_MASK_SPACE1 = 32'hffffe404;
  localparam logic [31:0] OFF_BASE_MASK_SPACE2 = 32'hffffe408;
  localparam logic [31:0] OFF_BASE_MASK_SPACE3 = 32'hffffe40c;
  localparam logic [31:0] OFF_SPACE_ENABLE = 32'hffffe480;
  localparam logic [31:0] OFF_SELECT_STATUS = 32'hffffe484;
  localparam int OFF_DECODE_BITS = 12;

  // ==========================================================================
  // Field layout of a base/mask register
  localparam int MASK_LSB = 0;
  localparam int BASE_LSB = 16;
  localparam int FIELD_W = 16;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_BASE_MASK_SPACE01 = 32'h000003ff;
  localparam logic [31:0] RST_BASE_MASK_SPACE23 = 32'h000001ff;
  localparam logic [3:0] RST_SPACE_ENABLE = 4'h4;

  // ==========================================================================
  // Mask field alignment: mask bit i governs address bit A(14 + i) or A(15 + i)
  localparam int SHIFT_SPACE01 = 2;
  localparam int SHIFT_SPACE23 = 1;

  // ==========================================================================
  // Address range in which no select is ever driven
  localparam logic [31:0] EXCLUDE_LOW = 32'hffff8000;
  localparam logic [31:0] EXCLUDE_HIGH = 32'h1fffbfff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// ==== hdl/csd_space_match.sv ====
// Purpose: Combinational address match for one chip select space.
// Assumes: base_mask holds the base field in [31:16] and the size mask in [15:0].
// Notes: MASK_SHIFT aligns mask bit 0 with address bit A14 or A15.
`timescale 1ns/10ps
module csd_space_match #(
  parameter int MASK_SHIFT = 2
) (
  input wire logic [31:0] base_mask,
  input wire logic [31:0] addr,
  output logic hit
);

  // ==========================================================================
  // Compare enables
  function automatic logic [15:0] care_bits(input logic [15:0] mask);
    logic [15:0] care;
    care = '1;
    for (int j = 0; j < 16; j++) begin
      if (j + MASK_SHIFT <= 15) begin
        care[j] = ~mask[j + MASK_SHIFT];
      end
    end
    return care;
  endfunction

  logic [15:0] care;
  logic [15:0] base;

  always_comb begin
    base = base_mask[csd_pkg::BASE_LSB +: csd_pkg::FIELD_W];
    care = care_bits(base_mask[csd_pkg::MASK_LSB +: csd_pkg::FIELD_W]);
    hit = (((addr[31:16] ^ base) & care) == 16'h0000);
  end

  generate
    if (MASK_SHIFT != 1 && MASK_SHIFT != 2) begin : g_bad_shift
      $error("csd_space_match: MASK_SHIFT must be 1 or 2.");
    end
  endgenerate

endmodule

// ==== hdl/csd_ahb_slave.sv ====
// Purpose: AHB-Lite slave front end for the decoder registers.
// Assumes: One slave on the bus; single word transfers only.
// Notes: Zero wait states; read data is registered from the address phase.
`timescale 1ns/10ps
module csd_ahb_slave (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [11:0] rd_offset,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [11:0] wr_offset,
  output logic [31:0] wr_data
);

  // ==========================================================================
  // Address phase capture
  logic take;
  logic pend_wr;
  logic [11:0] pend_off;
  logic next_pend_wr;
  logic [11:0] next_pend_off;
  logic [31:0] next_hrdata;

  always_comb begin
    take = hsel && hready && (htrans == csd_pkg::HTRANS_NONSEQ || htrans == csd_pkg::HTRANS_SEQ);
    next_pend_wr = take && hwrite && (hsize == 3'h2);
    next_pend_off = take ? haddr[11:0] : pend_off;
    rd_offset = haddr[11:0];
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      // A read right behind a write to the same word sees the new value.
      next_hrdata = (pend_wr && pend_off == haddr[11:0]) ? hwdata : rd_data;
    end
    wr_en = pend_wr;
    wr_offset = pend_off;
    wr_data = hwdata;
    hreadyout = 1'b1;
    hresp = 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pend_wr <= 1'b0;
      pend_off <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      pend_wr <= next_pend_wr;
      pend_off <= next_pend_off;
      hrdata <= next_hrdata;
    end
  end

endmodule

// ==== hdl/csd_decoder.sv ====
// Purpose: Chip select address decoder for four external spaces and a default space.
// Assumes: bus_addr is a physical address from the internal bus master.
// Notes: Selects are combinational from the address and the register contents.
//
// Behaviour
// - Mask bit 0 compares, 1 masks address bit.
// - Base field bits 31-16 compare with A31-A16.
// - Spaces 0/1 mask A29-A14; A31,A30 always compared.
// - Spaces 2/3 mask A30-A15; A31 compared, except space 2 while it spans all.
// - Match when all unmasked A31-A16 equal base.
// - Never select inside the excluded address range.
// - After reset only space 2, spanning all.
// - Lowest numbered enabled matching space wins alone.
// - Enable bits gate spaces; unmatched goes default.
`timescale 1ns/10ps
module csd_decoder #(
  parameter logic [31:0] EXCL_LOW = csd_pkg::EXCLUDE_LOW,
  parameter logic [31:0] EXCL_HIGH = csd_pkg::EXCLUDE_HIGH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  output logic [3:0] chip_select_n,
  output logic default_external_space_n
);

  // ==========================================================================
  // Bus front end
  logic [11:0] rd_offset;
  logic [31:0] rd_data;
  logic wr_en;
  logic [11:0] wr_offset;
  logic [31:0] wr_data;

  csd_ahb_slave u_slave (
    .mclk(mclk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_offset(rd_offset),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_offset(wr_offset),
    .wr_data(wr_data)
  );

  function automatic logic at(input logic [11:0] off, input logic [31:0] reg_off);
    return off == reg_off[csd_pkg::OFF_DECODE_BITS-1:0];
  endfunction

  // ==========================================================================
  // Registers
  logic [31:0] base_mask_space0;
  logic [31:0] base_mask_space1;
  logic [31:0] base_mask_space2;
  logic [31:0] base_mask_space3;
  logic [3:0] space_enable;
  logic space2_whole_range;
  logic [5:0] select_status;
  logic [31:0] next_base_mask_space0;
  logic [31:0] next_base_mask_space1;
  logic [31:0] next_base_mask_space2;
  logic [31:0] next_base_mask_space3;
  logic [3:0] next_space_enable;
  logic next_space2_whole_range;
  logic [5:0] next_select_status;

  // ==========================================================================
  // Decode
  logic [3:0] hit;
  logic [3:0] live;
  logic excluded;
  logic [3:0] sel;
  logic sel_default;

  csd_space_match #(.MASK_SHIFT(csd_pkg::SHIFT_SPACE01)) u_match0 (
    .base_mask(base_mask_space0),
    .addr(bus_addr),
    .hit(hit[0])
  );
  csd_space_match #(.MASK_SHIFT(csd_pkg::SHIFT_SPACE01)) u_match1 (
    .base_mask(base_mask_space1),
    .addr(bus_addr),
    .hit(hit[1])
  );
  csd_space_match #(.MASK_SHIFT(csd_pkg::SHIFT_SPACE23)) u_match2 (
    .base_mask(base_mask_space2),
    .addr(bus_addr),
    .hit(hit[2])
  );
  csd_space_match #(.MASK_SHIFT(csd_pkg::SHIFT_SPACE23)) u_match3 (
    .base_mask(base_mask_space3),
    .addr(bus_addr),
    .hit(hit[3])
  );

  always_comb begin
    // The excluded range may wrap through zero, so both orders are served.
    if (EXCL_LOW <= EXCL_HIGH) begin
      excluded = (bus_addr >= EXCL_LOW) && (bus_addr <= EXCL_HIGH);
    end else begin
      excluded = (bus_addr >= EXCL_LOW) || (bus_addr <= EXCL_HIGH);
    end
    live = {hit[3], hit[2] | space2_whole_range, hit[1], hit[0]} & space_enable;
    sel = 4'h0;
    sel_default = 1'b0;
    if (bus_valid && !excluded) begin
      if (live[0]) begin
        sel = 4'h1;
      end else if (live[1]) begin
        sel = 4'h2;
      end else if (live[2]) begin
        sel = 4'h4;
      end else if (live[3]) begin
        sel = 4'h8;
      end else begin
        sel_default = 1'b1;
      end
    end
    chip_select_n = ~sel;
    default_external_space_n = ~sel_default;
  end

  // ==========================================================================
  // Register write and status capture
  always_comb begin
    next_base_mask_space0 = base_mask_space0;
    next_base_mask_space1 = base_mask_space1;
    next_base_mask_space2 = base_mask_space2;
    next_base_mask_space3 = base_mask_space3;
    next_space_enable = space_enable;
    next_space2_whole_range = space2_whole_range;
    next_select_status = select_status;
    if (wr_en) begin
      if (at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE0)) begin
        next_base_mask_space0 = wr_data;
      end
      if (at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE1)) begin
        next_base_mask_space1 = wr_data;
      end
      if (at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE2)) begin
        next_base_mask_space2 = wr_data;
        // The reset-time full range ends once software programs space 2.
        next_space2_whole_range = 1'b0;
      end
      if (at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE3)) begin
        next_base_mask_space3 = wr_data;
      end
      if (at(wr_offset, csd_pkg::OFF_SPACE_ENABLE)) begin
        next_space_enable = wr_data[3:0];
      end
    end
    if (bus_valid) begin
      next_select_status = {excluded, sel_default, sel};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      base_mask_space0 <= csd_pkg::RST_BASE_MASK_SPACE01;
      base_mask_space1 <= csd_pkg::RST_BASE_MASK_SPACE01;
      base_mask_space2 <= csd_pkg::RST_BASE_MASK_SPACE23;
      base_mask_space3 <= csd_pkg::RST_BASE_MASK_SPACE23;
      space_enable <= csd_pkg::RST_SPACE_ENABLE;
      space2_whole_range <= 1'b1;
      select_status <= 6'h00;
    end else begin
      base_mask_space0 <= next_base_mask_space0;
      base_mask_space1 <= next_base_mask_space1;
      base_mask_space2 <= next_base_mask_space2;
      base_mask_space3 <= next_base_mask_space3;
      space_enable <= next_space_enable;
      space2_whole_range <= next_space2_whole_range;
      select_status <= next_select_status;
    end
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_data = 32'h00000000;
    if (at(rd_offset, csd_pkg::OFF_BASE_MASK_SPACE0)) begin
      rd_data = base_mask_space0;
    end else if (at(rd_offset, csd_pkg::OFF_BASE_MASK_SPACE1)) begin
      rd_data = base_mask_space1;
    end else if (at(rd_offset, csd_pkg::OFF_BASE_MASK_SPACE2)) begin
      rd_data = base_mask_space2;
    end else if (at(rd_offset, csd_pkg::OFF_BASE_MASK_SPACE3)) begin
      rd_data = base_mask_space3;
    end else if (at(rd_offset, csd_pkg::OFF_SPACE_ENABLE)) begin
      rd_data = {27'h0000000, space2_whole_range, space_enable};
    end else if (at(rd_offset, csd_pkg::OFF_SELECT_STATUS)) begin
      rd_data = {26'h0000000, select_status};
    end
  end

  // ==========================================================================
  // Checks
  chk_select_one_hot: assert property (@(posedge mclk) disable iff (!reset_n)
    $onehot0({~chip_select_n, ~default_external_space_n}))
    else $error("more than one select asserted");

  chk_space0_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    (bus_valid && !excluded && hit[0] && space_enable[0]) |-> (chip_select_n == 4'he))
    else $error("enabled space 0 hit did not win");

  chk_excluded_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    excluded |-> (chip_select_n == 4'hf && default_external_space_n))
    else $error("select driven inside excluded range");

  chk_reset_space2: assert property (@(posedge mclk) disable iff (!reset_n)
    (space2_whole_range && space_enable == csd_pkg::RST_SPACE_ENABLE && bus_valid && !excluded)
      |-> (chip_select_n == 4'hb))
    else $error("space 2 did not cover every address after reset");

  chk_top_bits_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    (!chip_select_n[0] || !chip_select_n[1])
      |-> (bus_addr[31:30] == (!chip_select_n[0] ? base_mask_space0[31:30]
                                                 : base_mask_space1[31:30])))
    else $error("A31 or A30 not compared for space 0 or 1");

  chk_a31_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    (!chip_select_n[3]) |-> (bus_addr[31] == base_mask_space3[31]))
    else $error("A31 not compared for space 3");

  chk_default_space: assert property (@(posedge mclk) disable iff (!reset_n)
    (bus_valid && !excluded && live == 4'h0) |-> !default_external_space_n)
    else $error("unmatched address did not reach the default space");

  chk_write_lands: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_en && at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE0))
      |=> (base_mask_space0 == $past(wr_data)))
    else $error("write to space 0 base/mask did not land");

  chk_status_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_valid |=> (select_status[3:0] == ~$past(chip_select_n)))
    else $error("status does not record the select of the last address");

  // The match units carry no clock, so their checks are made here on the bus clock.
  // A fully cleared mask must match every address in its 64 KB block.
  chk_full_mask_64k: assert property (@(posedge mclk) disable iff (!reset_n)
    (base_mask_space0[15:0] == 16'h0000 && bus_addr[31:16] == base_mask_space0[31:16]) |-> hit[0])
    else $error("cleared mask with equal upper bits did not match");

  // A disabled space must never drive its select, whatever its match says.
  chk_disabled_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    (((~chip_select_n) & ~space_enable) == 4'h0))
    else $error("select driven for a disabled space");

  // Once programmed, space 2 compares A31 like space 3 does.
  chk_a31_space2: assert property (@(posedge mclk) disable iff (!reset_n)
    (!chip_select_n[2] && !space2_whole_range) |-> (bus_addr[31] == base_mask_space2[31]))
    else $error("A31 not compared for space 2");

  chk_space1_wins: assert property (@(posedge mclk) disable iff (!reset_n)
    (bus_valid && !excluded && live[1] && !live[0]) |-> (chip_select_n == 4'hd))
    else $error("enabled space 1 hit did not win over lower priorities");

  chk_space3_last: assert property (@(posedge mclk) disable iff (!reset_n)
    (!chip_select_n[3]) |-> (live == 4'h8))
    else $error("space 3 selected although a higher priority space matched");

  // With no address on the bus every select line rests high.
  chk_invalid_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    (!bus_valid) |-> (chip_select_n == 4'hf && default_external_space_n))
    else $error("select driven without a valid address");

  chk_whole_range_ends: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_en && at(wr_offset, csd_pkg::OFF_BASE_MASK_SPACE2)) |=> !space2_whole_range)
    else $error("space 2 kept its reset range after being programmed");

  chk_enable_lands: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_en && at(wr_offset, csd_pkg::OFF_SPACE_ENABLE))
      |=> ({28'h0000000, space_enable} == ($past(wr_data) & 32'h0000000f)))
    else $error("write to the space enable register did not land");

endmodule

// ==== sim/csd_ext_devices.sv ====
// Purpose: Model of the external devices that hang on the chip select lines.
// Assumes: Every select is active low and the default device always answers.
// Notes: Reports which device answers and flags two devices answering at once.
`timescale 1ns/10ps
module csd_ext_devices (
  input wire logic [3:0] chip_select_n,
  input wire logic default_external_space_n,
  output logic [2:0] resp_id,
  output logic clash
);
  logic [4:0] sel_n;
  assign sel_n = {default_external_space_n, chip_select_n};
  // ==========================================================================
  // Responder
  always_comb begin
    resp_id = 3'h7;
    clash = 1'h0;
    for (int i = 4; i >= 0; i--) begin
      if (sel_n[i] == 1'h0) begin
        clash = clash | (resp_id != 3'h7);
        resp_id = 3'(i);
      end
    end
  end
endmodule

// ==== sim/chip_select_address_decoder_bench.sv ====
// Purpose: Self-checking bench for the chip select address decoder.
// Assumes: Zero wait state register slave; selects settle in the address cycle.
// Notes: A queue-free integer model predicts every select and register read.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module chip_select_address_decoder_bench;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic bus_valid = 1'h0;
  logic [31:0] bus_addr = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] chip_select_n;
  logic default_external_space_n;
  logic clash;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h1f59;
  logic [31:0] bm [4];
  logic [3:0] en;
  logic whole;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] pts [7] = '{32'h20000000, 32'hffff7fff, 32'hffff8000, 32'h1fffbfff,
    32'h1fffc000, 32'h00000000, 32'hc0001234};

  always #2 mclk = ~mclk;

  csd_decoder dut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .bus_valid, .bus_addr,
    .chip_select_n, .default_external_space_n);
  csd_ext_devices ext (.chip_select_n, .default_external_space_n, .resp_id(), .clash);

  // ==========================================================================
  // Model
  function automatic logic [31:0] lfsr();
    seed = (seed >> 1) ^ (seed[0] ? 32'hedb88320 : 32'h0);
    return seed;
  endfunction

  function automatic logic [4:0] model(input logic v, input logic [31:0] a);
    logic hit;
    if (!v || a >= csd_pkg::EXCLUDE_LOW || a <= csd_pkg::EXCLUDE_HIGH) begin
      return 5'h1f;
    end
    for (int i = 0; i < 4; i++) begin
      hit = en[i];
      for (int b = 16; b < 32; b++) begin
        if (!(i < 2 ? (b < 30 && bm[i][b - 14]) : (b < 31 && bm[i][b - 15])) && a[b] != bm[i][b]) begin
          hit = 1'h0;
        end
      end
      if (i == 2 && whole) begin
        hit = en[2];
      end
      if (hit) begin
        return {1'h1, ~(4'h1 << i)};
      end
    end
    return 5'h0f;
  endfunction

  // ==========================================================================
  // Bus and decode tasks
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end
    else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      err_count++;
      $display("[ERR] %0t bus hang", $time);
      close_out();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= csd_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'h0)
  endtask

  function automatic logic [31:0] reg_addr(input int i);
    return i < 4 ? csd_pkg::OFF_BASE_MASK_SPACE0 + 32'(4 * i) : csd_pkg::OFF_SPACE_ENABLE;
  endfunction

  task automatic rd_chk(input int i);
    xfer(1'h0, reg_addr(i), 32'h0);
    `CHK(rd, i < 4 ? bm[i] : {27'h0, whole, en})
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d);
    xfer(1'h1, reg_addr(i), d);
    if (i < 4) begin
      bm[i] = d;
    end
    else begin
      en = d[3:0];
    end
    if (i == 2) begin
      whole = 1'h0;
    end
    rd_chk(i);
  endtask

  task automatic dec(input logic v, input logic [31:0] a);
    @(posedge mclk);
    bus_valid <= v;
    bus_addr <= a;
    #1;
    `CHK({default_external_space_n, chip_select_n}, model(v, a))
    `CHK(clash, 1'h0)
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    whole = 1'h1;
    en = csd_pkg::RST_SPACE_ENABLE;
    bm = '{csd_pkg::RST_BASE_MASK_SPACE01, csd_pkg::RST_BASE_MASK_SPACE01,
      csd_pkg::RST_BASE_MASK_SPACE23, csd_pkg::RST_BASE_MASK_SPACE23};
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    for (int i = 0; i < 5; i++) rd_chk(i);
    xfer(1'h0, 32'hffffe490, 32'h0);
    `CHK(rd, 32'h0)
    foreach (pts[k]) dec(1'h1, pts[k]);
    dec(1'h0, 32'h40000000);
    // A cleared mask gives a 64 KB block at the programmed base.
    wr_reg(0, 32'hc0000000);
    wr_reg(4, 32'h5);
    dec(1'h1, 32'hc000ffff);
    dec(1'h1, 32'hc0010000);
    dec(1'h1, 32'hbfffffff);
    xfer(1'h0, csd_pkg::OFF_SELECT_STATUS, 32'h0);
    `CHK(rd, {26'h0, 1'h0, ~model(1'h1, 32'hbfffffff)})
    dec(1'h1, 32'h00000000);
    xfer(1'h0, csd_pkg::OFF_SELECT_STATUS, 32'h0);
    `CHK(rd, 32'h00000020)
    // A halfword write must leave the register untouched.
    hsize <= 3'h1;
    xfer(1'h1, reg_addr(3), 32'h12345678);
    hsize <= 3'h2;
    rd_chk(3);
    for (int c = 0; c < 30; c++) begin
      for (int i = 0; i < 4; i++) begin
        r = lfsr();
        wr_reg(i, {1'h1, r[30], 6'h0, r[23:16], (16'h1 << (r[3:0] % (i < 2 ? 11 : 10))) - 16'h1});
      end
      wr_reg(4, lfsr());
      repeat (16) begin
        r = lfsr();
        dec(r[31:29] != 3'h0, r[28] ? lfsr() : {1'h1, r[30], 6'h0, r[23:0]});
      end
    end
    close_out();
  end
endmodule
